// file: oled_cmd_pkg.sv
// Constants for the display command interpreter and pixel access logic.
// Assumes a host byte port already reduced to write and read strobes.
package oled_cmd_pkg;
  localparam logic [7:0] CMD_COL_ADDR = 8'h15;
  localparam logic [7:0] CMD_ROW_ADDR = 8'h75;
  localparam logic [7:0] CMD_CONTRAST = 8'h81;
  localparam logic [7:0] CMD_PRE2_SPEED = 8'h82;
  localparam logic [7:0] CMD_ICON_MASTER = 8'h90;
  localparam logic [7:0] CMD_ICON_RANGE = 8'h91;
  localparam logic [7:0] CMD_ICON_CURR = 8'h92;
  localparam logic [7:0] CMD_ICON_ONE = 8'h93;
  localparam logic [7:0] CMD_ICON_ALL = 8'h94;
  localparam logic [7:0] CMD_ICON_BLINK = 8'h95;
  localparam logic [7:0] CMD_ICON_DUTY = 8'h96;
  localparam logic [7:0] CMD_REMAP = 8'hA0;
  localparam logic [7:0] CMD_SLEEP_ON = 8'hAE;
  localparam logic [7:0] CMD_SLEEP_OFF = 8'hAF;
  localparam logic [7:0] CMD_PRE1_LEVEL = 8'hBC;
  localparam logic [7:0] CMD_COMH = 8'hBE;
  localparam logic [7:0] CMD_NOP = 8'hE3;
  localparam logic [7:0] CMD_LOCK = 8'hFD;
  localparam logic [7:0] LOCK_ARG_MASK = 8'hFB;
  localparam logic [7:0] LOCK_ARG_BASE = 8'h12;
  localparam int LOCK_BIT = 2;
  localparam int INC_DIR_BIT = 2;
  localparam int STATUS_OFF_BIT = 6;
  localparam logic [5:0] PRE1_RESET = 6'h0F;
  localparam logic [6:0] COMH_RESET = 7'h1F;
  localparam logic [7:0] CONTRAST_RESET = 8'h7F;
  localparam logic [7:0] ICON_RANGE_RESET = 8'hFF;
  localparam logic [7:0] ICON_BLINK_RESET = 8'h13;
  localparam logic [7:0] ICON_DUTY_RESET = 8'h00;
  localparam logic [7:0] REMAP_RESET = 8'h00;
  localparam logic [6:0] COL_END_RESET = 7'h7F;
  localparam logic [6:0] ROW_END_RESET = 7'h7F;
  localparam int ICON_COUNT = 64;
  localparam int ADDR_W = 7;
  localparam int COLS = 128;
  localparam int ROWS = 128;
  localparam int PIX_W = 8;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ARG1 = 5'b00010,
    ST_ARG2 = 5'b00100,
    ST_ICON = 5'b01000,
    ST_LOCK = 5'b10000
  } parse_t;
endpackage

// file: pixel_buffer_ram.sv
// Pixel store for the display window, one byte per column and row cell.
// Assumes one access per clock, synchronous read with one cycle latency.
`timescale 1ns/1ps
`default_nettype none
module pixel_buffer_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock.
  input wire logic clk_sys,
  // Access port.
  input wire logic wr_en,
  input wire logic [AW-1:0] col,
  input wire logic [AW-1:0] row,
  input wire logic [DW-1:0] wr_data,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [0:(1<<(2*AW))-1];

  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[{row, col}] <= wr_data;
    end
    rd_data <= mem[{row, col}];
  end
endmodule // pixel_buffer_ram
`default_nettype wire

// file: oled_command_and_ram_access.sv
// Command decoder, window pointers and pixel access of the display driver.
// Assumes the host port logic delivers one strobe per byte, with the
// data/command select beside it, synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module oled_command_and_ram_access
  import oled_cmd_pkg::*;
#(
  parameter int ICONS = oled_cmd_pkg::ICON_COUNT
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Host byte port.
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic host_dc,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  // Stored settings.
  output logic [5:0] pre1_level,
  output logic [6:0] common_high_level,
  output logic [7:0] contrast,
  output logic pre2_double,
  output logic [7:0] icon_master,
  output logic [7:0] icon_range,
  output logic [7:0] icon_blink,
  output logic [7:0] icon_duty,
  output logic [7:0] remap,
  output logic display_on,
  output logic cmd_locked,
  output logic [2*ICONS-1:0] icon_state,
  output logic [7*ICONS-1:0] icon_segment_output
);
  import oled_cmd_pkg::*;

  if (ICONS != ICON_COUNT)
  begin : g_bad_icon_count
    $error("Icon count must be 64.");
  end

  ////////////////////////////////////////////////////////////////////////
  // Command parser.

  function automatic logic two_arg(input logic [7:0] c);
    two_arg = (c == CMD_COL_ADDR) || (c == CMD_ROW_ADDR);
  endfunction

  function automatic logic one_arg(input logic [7:0] c);
    case (c)
      CMD_CONTRAST, CMD_PRE2_SPEED, CMD_ICON_MASTER, CMD_ICON_RANGE,
      CMD_ICON_ONE, CMD_ICON_ALL, CMD_ICON_BLINK, CMD_ICON_DUTY,
      CMD_REMAP, CMD_PRE1_LEVEL, CMD_COMH: one_arg = 1'b1;
      default: one_arg = 1'b0;
    endcase
  endfunction

  parse_t state;
  logic [7:0] opcode;
  logic [6:0] first_arg;
  logic [5:0] icon_idx;
  logic [6:0] col_start, col_end, row_start, row_end;
  logic [6:0] col_ptr, row_ptr;
  logic [7:0] icon_cur [0:ICONS-1];
  logic dummy_pending;
  logic [7:0] ram_q;

  wire cmd_wr = host_wr && !host_dc;
  wire arg_done = cmd_wr && (state == ST_ARG1) && !two_arg(opcode);
  wire arg2_done = cmd_wr && (state == ST_ARG2);

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      opcode <= 8'h00;
      icon_idx <= 6'h00;
    end
    else if (cmd_wr)
    begin
      unique case (state)
        ST_IDLE:
        begin
          opcode <= host_wdata;
          if (host_wdata == CMD_LOCK)
            state <= ST_LOCK;
          else if (cmd_locked)
            state <= ST_IDLE;
          else if (host_wdata == CMD_ICON_CURR)
          begin
            state <= ST_ICON;
            icon_idx <= 6'h00;
          end
          else if (two_arg(host_wdata) || one_arg(host_wdata))
            state <= ST_ARG1;
          else
            state <= ST_IDLE;
        end
        ST_ARG1:
          state <= two_arg(opcode) ? ST_ARG2 : ST_IDLE;
        ST_ARG2:
          state <= ST_IDLE;
        ST_ICON:
        begin
          icon_idx <= icon_idx + 6'h01;
          if (icon_idx == 6'(ICONS - 1))
            state <= ST_IDLE;
        end
        ST_LOCK:
          state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Lock engage and release.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      cmd_locked <= 1'b0;
    else if (cmd_wr && state == ST_LOCK &&
             (host_wdata & LOCK_ARG_MASK) == LOCK_ARG_BASE)
      cmd_locked <= host_wdata[LOCK_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // Setting registers.

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      pre1_level <= PRE1_RESET;
      common_high_level <= COMH_RESET;
      contrast <= CONTRAST_RESET;
      pre2_double <= 1'b0;
      icon_master <= 8'h00;
      icon_range <= ICON_RANGE_RESET;
      icon_blink <= ICON_BLINK_RESET;
      icon_duty <= ICON_DUTY_RESET;
      remap <= REMAP_RESET;
    end
    else if (arg_done)
    begin
      case (opcode)
        CMD_PRE1_LEVEL: pre1_level <= host_wdata[5:0];
        CMD_COMH: common_high_level <= host_wdata[6:0];
        CMD_CONTRAST: contrast <= host_wdata;
        CMD_PRE2_SPEED: pre2_double <= host_wdata[0];
        CMD_ICON_MASTER: icon_master <= host_wdata;
        CMD_ICON_RANGE: icon_range <= host_wdata;
        CMD_ICON_BLINK: icon_blink <= host_wdata;
        CMD_ICON_DUTY: icon_duty <= host_wdata;
        CMD_REMAP: remap <= host_wdata;
        default: ;
      endcase
    end
  end

  // Display on and off for the status byte.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      display_on <= 1'b0;
    else if (cmd_wr && state == ST_IDLE && !cmd_locked)
    begin
      if (host_wdata == CMD_SLEEP_OFF)
        display_on <= 1'b1;
      else if (host_wdata == CMD_SLEEP_ON)
        display_on <= 1'b0;
    end
  end

  // Icon per-icon state and staged current bytes.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      icon_state <= '0;
    else if (arg_done && opcode == CMD_ICON_ONE)
      icon_state[2*host_wdata[5:0] +: 2] <= host_wdata[7:6];
    else if (arg_done && opcode == CMD_ICON_ALL)
      icon_state <= {ICONS{host_wdata[7:6]}};
  end

  always_ff @(posedge clk_sys)
    if (cmd_wr && state == ST_ICON)
      icon_cur[icon_idx] <= host_wdata;

  // The bank takes effect only when the last of the 64 bytes lands.
  generate
    for (genvar i = 0; i < ICONS; i++)
    begin : g_icon
      always_ff @(posedge clk_sys)
      begin
        if (!reset_n)
          icon_segment_output[7*i +: 7] <= 7'h00;
        else if (cmd_wr && state == ST_ICON && icon_idx == 6'(ICONS - 1))
          icon_segment_output[7*i +: 7] <= (i == ICONS - 1) ?
            host_wdata[6:0] : icon_cur[i][6:0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Window pointers.

  wire data_acc = (host_wr || host_rd) && host_dc && !cmd_locked;
  wire vert = remap[INC_DIR_BIT];
  wire col_wrap = (col_ptr == col_end);
  wire row_wrap = (row_ptr == row_end);

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      col_start <= '0;
      col_end <= COL_END_RESET;
      row_start <= '0;
      row_end <= ROW_END_RESET;
      col_ptr <= '0;
      row_ptr <= '0;
      first_arg <= '0;
    end
    else if (cmd_wr && state == ST_ARG1)
      first_arg <= host_wdata[6:0];
    else if (arg2_done && opcode == CMD_COL_ADDR)
    begin
      col_start <= first_arg;
      col_end <= host_wdata[6:0];
      col_ptr <= first_arg;
    end
    else if (arg2_done && opcode == CMD_ROW_ADDR)
    begin
      row_start <= first_arg;
      row_end <= host_wdata[6:0];
      row_ptr <= first_arg;
    end
    else if (data_acc && !(host_rd && dummy_pending))
    begin
      if (!vert)
      begin
        col_ptr <= col_wrap ? col_start : col_ptr + 7'h01;
        if (col_wrap)
          row_ptr <= row_wrap ? row_start : row_ptr + 7'h01;
      end
      else
      begin
        row_ptr <= row_wrap ? row_start : row_ptr + 7'h01;
        if (row_wrap)
          col_ptr <= col_wrap ? col_start : col_ptr + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pixel access and host read data.

  // A dummy read loads the pipeline without moving the pointers.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      dummy_pending <= 1'b1;
    else if (arg2_done)
      dummy_pending <= 1'b1;
    else if (data_acc && host_rd)
      dummy_pending <= 1'b0;
  end

  pixel_buffer_ram #(
    .AW(ADDR_W),
    .DW(PIX_W)
  ) u_ram (
    .clk_sys(clk_sys),
    .wr_en(data_acc && host_wr),
    .col(col_ptr),
    .row(row_ptr),
    .wr_data(host_wdata),
    .rd_data(ram_q)
  );
  logic rd_data_q, rd_dummy_q;
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      rd_data_q <= 1'b0;
      rd_dummy_q <= 1'b0;
      host_rvalid <= 1'b0;
      host_rdata <= 8'h00;
    end
    else
    begin
      rd_data_q <= data_acc && host_rd;
      rd_dummy_q <= dummy_pending;
      host_rvalid <= 1'b0;
      if (host_rd && !host_dc)
      begin
        host_rvalid <= 1'b1;
        host_rdata <= 8'h00;
        host_rdata[STATUS_OFF_BIT] <= !display_on;
      end
      else if (rd_data_q)
      begin
        host_rvalid <= 1'b1;
        host_rdata <= rd_dummy_q ? 8'h00 : ram_q;
      end
    end
  end
endmodule // oled_command_and_ram_access
`default_nettype wire

// file: oled_cmd_assertions.sv
// Checker for the command decoder: settings, lock and read answers.
// Assumes it is bound to the decoder top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module oled_cmd_assertions (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Host port.
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic host_dc,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  // Settings.
  input wire logic [5:0] pre1_level,
  input wire logic [6:0] common_high_level,
  input wire logic [7:0] contrast,
  input wire logic [7:0] remap,
  input wire logic display_on,
  input wire logic cmd_locked
);
  import oled_cmd_pkg::*;
  logic cw;
  logic [7:0] prev_cmd;
  assign cw = host_wr && !host_dc;
  // Remembers the command byte of the previous strobe, 00 otherwise.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      prev_cmd <= 8'h00;
    else if (host_wr || host_rd)
      prev_cmd <= cw ? host_wdata : 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_reset_levels:
    assert property ($rose(reset_n) |-> pre1_level == PRE1_RESET &&
      common_high_level == COMH_RESET && !cmd_locked)
    else $error("settings wrong after reset");
  a_status_answer:
    assert property (host_rd && !host_dc |=> host_rvalid &&
      host_rdata == {1'b0, !$past(display_on), 6'h00})
    else $error("status answer wrong");
  a_data_read:
    assert property (host_rd && host_dc && !cmd_locked |-> ##2 host_rvalid)
    else $error("data read not answered");
  a_lock_engage:
    assert property (cw && prev_cmd == CMD_LOCK && host_wdata == 8'h16
      |=> cmd_locked)
    else $error("lock not engaged");
  a_lock_release:
    assert property (cw && prev_cmd == CMD_LOCK &&
      host_wdata == LOCK_ARG_BASE |=> !cmd_locked)
    else $error("lock not released");
  a_locked_ignore:
    assert property (cmd_locked && cw && prev_cmd != CMD_LOCK |=>
      $stable(contrast) && $stable(display_on) && $stable(remap))
    else $error("locked command took effect");
  a_nop_quiet:
    assert property (cw && host_wdata == CMD_NOP |=> $stable(contrast) &&
      $stable(pre1_level) && $stable(cmd_locked) && $stable(display_on))
    else $error("no-operation changed state");
  a_pre1_store:
    assert property (!cmd_locked && cw && prev_cmd == CMD_PRE1_LEVEL |=>
      {2'b00, pre1_level} == ($past(host_wdata) & 8'h3F))
    else $error("pre-charge level not stored");
  a_contrast_store:
    assert property (!cmd_locked && cw && prev_cmd == CMD_CONTRAST |=>
      contrast == $past(host_wdata))
    else $error("contrast not stored");
  c_locked: cover property (cmd_locked && cw);
  c_data_read: cover property (host_rd && host_dc && !cmd_locked);
  c_status: cover property (host_rd && !host_dc);
endmodule // oled_cmd_assertions
bind oled_command_and_ram_access oled_cmd_assertions u_oled_cmd_assertions (
  .clk_sys(clk_sys), .reset_n(reset_n), .host_wr(host_wr),
  .host_rd(host_rd), .host_dc(host_dc), .host_wdata(host_wdata),
  .host_rdata(host_rdata), .host_rvalid(host_rvalid),
  .pre1_level(pre1_level), .common_high_level(common_high_level),
  .contrast(contrast), .remap(remap), .display_on(display_on),
  .cmd_locked(cmd_locked)
);
`default_nettype wire

// file: oled_host_model.sv
// Host microcontroller model that strobes bytes into the decoder.
// Assumes one strobe at a time, launched just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module oled_host_model (
  // Clock.
  input wire logic clk_sys,
  // Byte port.
  output logic host_wr,
  output logic host_rd,
  output logic host_dc,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid
);
  initial
  begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_dc = 1'b0;
    host_wdata = 8'h00;
  end
  // Write strobe; the data lines show the inverse once released.
  // It returns at the falling edge, so the caller sees settled outputs.
  task automatic put(input logic dc, input logic [7:0] b);
    @(posedge clk_sys);
    host_wr <= 1'b1;
    host_dc <= dc;
    host_wdata <= b;
    @(posedge clk_sys);
    host_wr <= 1'b0;
    host_wdata <= ~b;
    @(negedge clk_sys);
  endtask
  // Read strobe; the answer is awaited for at most four cycles.
  task automatic get(input logic dc, output logic [7:0] d, output logic ok);
    int n;
    @(posedge clk_sys);
    host_rd <= 1'b1;
    host_dc <= dc;
    @(posedge clk_sys);
    host_rd <= 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (n = 0; n < 4 && !ok; n++)
    begin
      @(posedge clk_sys);
      ok = host_rvalid;
      d = host_rdata;
    end
  endtask
endmodule // oled_host_model
`default_nettype wire

// file: oled_command_and_ram_access_test.sv
// Self-checking bench for the command decoder and pixel access.
// Assumes the host model strobes the port and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module oled_command_and_ram_access_test;
  import oled_cmd_pkg::*;
  logic clk_sys, reset_n, host_wr, host_rd, host_dc, host_rvalid;
  logic pre2_double, display_on, cmd_locked;
  logic [7:0] host_wdata, host_rdata, contrast, icon_master, icon_range;
  logic [7:0] icon_blink, icon_duty, remap;
  logic [5:0] pre1_level;
  logic [6:0] common_high_level;
  logic [127:0] icon_state;
  logic [447:0] icon_segment_output;
  int failures, compares;
  oled_host_model u_oled_host_model (.clk_sys(clk_sys), .host_wr(host_wr),
    .host_rd(host_rd), .host_dc(host_dc), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid));
  oled_command_and_ram_access u_oled_command_and_ram_access (
    .clk_sys(clk_sys), .reset_n(reset_n), .host_wr(host_wr),
    .host_rd(host_rd), .host_dc(host_dc), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .pre1_level(pre1_level), .common_high_level(common_high_level),
    .contrast(contrast), .pre2_double(pre2_double),
    .icon_master(icon_master), .icon_range(icon_range),
    .icon_blink(icon_blink), .icon_duty(icon_duty), .remap(remap),
    .display_on(display_on), .cmd_locked(cmd_locked),
    .icon_state(icon_state), .icon_segment_output(icon_segment_output));
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd2(input logic [7:0] op, input logic [7:0] a);
    u_oled_host_model.put(1'b0, op);
    u_oled_host_model.put(1'b0, a);
  endtask
  task automatic cmd3(input logic [7:0] op, input logic [7:0] a,
    input logic [7:0] b);
    cmd2(op, a);
    u_oled_host_model.put(1'b0, b);
  endtask
  task automatic rd_chk(input logic dc, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_oled_host_model.get(dc, d, ok);
    if (!ok)
    begin
      failures++;
      wrap_up();
    end
    check(d, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_settings();
    check(pre1_level, PRE1_RESET);
    check(common_high_level, COMH_RESET);
    check(remap, 8'h00);
    rd_chk(1'b0, 8'h40);
    cmd2(8'hBC, 8'h3F);
    check(pre1_level, 6'h3F);
    cmd2(8'hBE, 8'h55);
    check(common_high_level, 7'h55);
    cmd2(8'h81, 8'hFF);
    check(contrast, 8'hFF);
    cmd2(8'h82, 8'h01);
    check(pre2_double, 1'b1);
    cmd2(8'h90, 8'h31);
    check(icon_master, 8'h31);
    cmd2(8'h91, 8'h00);
    check(icon_range, 8'h00);
    cmd2(8'h95, 8'h25);
    check(icon_blink, 8'h25);
    cmd2(8'h96, 8'hF3);
    check(icon_duty, 8'hF3);
    cmd2(8'h94, 8'h40);
    check(icon_state, {64{2'b01}});
    cmd2(8'h93, 8'hC5);
    check(icon_state[11:8], 4'hD);
    u_oled_host_model.put(1'b0, CMD_NOP);
    check({contrast, pre1_level}, {8'hFF, 6'h3F});
    u_oled_host_model.put(1'b0, CMD_SLEEP_OFF);
    rd_chk(1'b0, 8'h00);
  endtask
  task automatic t_window();
    logic [7:0] h[5] = '{8'h00, 8'h55, 8'h22, 8'h33, 8'h44};
    logic [7:0] v[5] = '{8'h00, 8'h55, 8'h33, 8'h22, 8'h44};
    cmd3(CMD_COL_ADDR, 8'h02, 8'h03);
    cmd3(CMD_ROW_ADDR, 8'h01, 8'h02);
    foreach (h[i])
      u_oled_host_model.put(1'b1, 8'(8'h11 * (i + 1)));
    cmd3(CMD_COL_ADDR, 8'h02, 8'h03);
    foreach (h[i])
    begin
      rd_chk(1'b1, h[i]);
      rd_chk(1'b0, 8'h00);
    end
    cmd2(CMD_REMAP, 8'h04);
    check(remap, 8'h04);
    cmd3(CMD_COL_ADDR, 8'h02, 8'h03);
    cmd3(CMD_ROW_ADDR, 8'h01, 8'h02);
    foreach (v[i])
      rd_chk(1'b1, v[i]);
  endtask
  task automatic t_lock();
    logic [7:0] d;
    logic ok;
    cmd2(CMD_LOCK, 8'h16);
    check(cmd_locked, 1'b1);
    cmd2(8'h81, 8'h10);
    check(contrast, 8'hFF);
    u_oled_host_model.put(1'b0, CMD_SLEEP_ON);
    u_oled_host_model.get(1'b1, d, ok);
    check(ok, 1'b0);
    rd_chk(1'b0, 8'h00);
    cmd2(CMD_LOCK, LOCK_ARG_BASE);
    check(cmd_locked, 1'b0);
    u_oled_host_model.put(1'b0, CMD_SLEEP_ON);
    rd_chk(1'b0, 8'h40);
  endtask
  task automatic t_reset();
    cmd2(CMD_LOCK, 8'h16);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    check(cmd_locked, 1'b0);
    check({pre1_level, common_high_level}, {PRE1_RESET, COMH_RESET});
    check({remap, contrast}, {REMAP_RESET, CONTRAST_RESET});
  endtask
  task automatic t_icons();
    u_oled_host_model.put(1'b0, CMD_ICON_CURR);
    for (int i = 0; i < 64; i++)
      u_oled_host_model.put(1'b0, 8'(i));
    for (int i = 0; i < 64; i++)
      check(icon_segment_output[7*i+:7], 7'(i));
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    failures = 0;
    compares = 0;
    reset_n = 1'b0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_settings();
    t_window();
    t_lock();
    t_icons();
    t_reset();
    wrap_up();
  end
endmodule // oled_command_and_ram_access_test
`default_nettype wire
